/* rtl/dmc_pkg.sv */
package dmc_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [3:0] DMC_ADDR_REFRESH = 4'h0;
   localparam logic [3:0] DMC_ADDR_MODE_TWO = 4'h4;
   localparam logic [3:0] DMC_ADDR_SYNC = 4'h8;
   localparam logic [3:0] DMC_ADDR_STATUS = 4'hC;

   // ----------------------------------------------------------------
   // Field positions of display_mode_two
   // ----------------------------------------------------------------
   localparam int DMC_CDE_OFF_BIT = 12;
   localparam int DMC_PRI_HI_BIT = 11;
   localparam int DMC_FMT_BIT = 10;
   localparam int DMC_ORIGIN_BIT = 9;
   localparam int DMC_CSY_HI_BIT = 7;
   localparam int DMC_CSY_LO_BIT = 6;
   localparam int DMC_PRI_LO_BIT = 5;

   // ----------------------------------------------------------------
   // Reset values and encodings
   // ----------------------------------------------------------------
   localparam logic [3:0] DMC_REFRESH_RST = 4'h8;
   localparam logic [1:0] DMC_SYNC_RST = 2'h2;
   localparam logic [1:0] DMC_SYNC_TV = 2'h2;
   localparam logic [9:0] DMC_ORIGIN_HALF = 10'h200;
   localparam logic [1:0] DMC_RESP_OKAY = 2'h0;
   localparam logic [1:0] DMC_RESP_SLVERR = 2'h2;

   // Layer identifiers, packed top first, three bits each
   localparam logic [2:0] DMC_L_CUR1 = 3'h0;
   localparam logic [2:0] DMC_L_CUR2 = 3'h1;
   localparam logic [2:0] DMC_L_FG = 3'h2;
   localparam logic [2:0] DMC_L_VID = 3'h3;
   localparam logic [2:0] DMC_L_BG = 3'h4;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int DMC_CLK_PERIOD_NS = 10;
   localparam int DMC_REFRESH_CYCLE_NS = 40;
   localparam int DMC_REFRESH_GAP_CYC =
      (DMC_REFRESH_CYCLE_NS + DMC_CLK_PERIOD_NS - 1) / DMC_CLK_PERIOD_NS;

   typedef struct packed {
      logic cde_pin_o;
      logic cde_pin_oe;
      logic own_rgb_sel;
      logic yc_convert;
      logic [9:0] fg1_origin_x;
      logic [14:0] layer_order;
      logic csync_n;
      logic tv_sync_mode;
   } dmc_disp_t;

   function automatic logic [14:0] dmc_layer_order(input logic [1:0] layer_priority_low);
      case (layer_priority_low)
         2'h2: dmc_layer_order = {DMC_L_CUR1, DMC_L_FG, DMC_L_VID, DMC_L_CUR2, DMC_L_BG};
         2'h3: dmc_layer_order = {DMC_L_FG, DMC_L_VID, DMC_L_CUR1, DMC_L_CUR2, DMC_L_BG};
         default: dmc_layer_order = {DMC_L_CUR1, DMC_L_CUR2, DMC_L_FG, DMC_L_VID, DMC_L_BG};
      endcase
   endfunction : dmc_layer_order

endpackage : dmc_pkg

/* rtl/dmc_refresh_gen.sv */
`timescale 1ns/10ps
module dmc_refresh_gen
   import dmc_pkg::*;
#(
   parameter int CNT_W = 4,
   parameter int GAP_CYC = DMC_REFRESH_GAP_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic raster_start,
   input wire logic display_area,
   input wire logic [CNT_W-1:0] refresh_count,
   output logic refresh_strobe,
   output logic busy
);

   typedef enum logic {DMC_RG_IDLE, DMC_RG_RUN} dmc_rg_state_t;

   if (CNT_W < 1 || GAP_CYC < 1 || GAP_CYC > 255) begin : g_chk
      $error("dmc_refresh_gen: unsupported parameters");
   end

   dmc_rg_state_t state_q, state_d;
   logic [CNT_W-1:0] left_q, left_d;
   logic [7:0] gap_q, gap_d;
   logic strobe_q, strobe_d;

   // ----------------------------------------------------------------
   // Refresh burst sequencer
   // ----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      left_d = left_q;
      gap_d = gap_q;
      strobe_d = 1'b0;
      case (state_q)
         DMC_RG_IDLE: begin
            if (raster_start && display_area && refresh_count != '0) begin
               state_d = DMC_RG_RUN;
               left_d = refresh_count;
               gap_d = 8'h00;
            end
         end
         DMC_RG_RUN: begin
            if (gap_q == 8'h00) begin
               strobe_d = 1'b1;
               gap_d = 8'(GAP_CYC - 1);
               left_d = left_q - 1'b1;
               if (left_q == CNT_W'(1)) begin
                  state_d = DMC_RG_IDLE;
               end
            end else begin
               gap_d = gap_q - 8'h01;
            end
         end
         default: state_d = DMC_RG_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= DMC_RG_IDLE;
         left_q <= '0;
         gap_q <= 8'h00;
         strobe_q <= 1'b0;
      end else begin
         state_q <= state_d;
         left_q <= left_d;
         gap_q <= gap_d;
         strobe_q <= strobe_d;
      end
   end

   assign refresh_strobe = strobe_q;
   assign busy = (state_q == DMC_RG_RUN);

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic [CNT_W-1:0] want_q;
   logic [CNT_W:0] sent_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         want_q <= '0;
         sent_q <= '0;
      end else if (state_q == DMC_RG_IDLE && state_d == DMC_RG_RUN) begin
         want_q <= refresh_count;
         sent_q <= '0;
      end else if (strobe_q) begin
         sent_q <= sent_q + 1'b1;
      end
   end

   AST_BURST_COUNT: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(busy) |=> sent_q == {1'b0, want_q})
      else $error("refresh burst length differs from count");

endmodule : dmc_refresh_gen

/* rtl/dmc_display_mode_control.sv */
//
// What this block does
// - Count n gives n refreshes per raster that starts in display area
// - Count zero gives no refresh timing
// - Refresh count resets to eight
// - Reset keeps composite sync bits, clears rest
// - Bit 12 set disables composite enable pin
// - TV sync: pin selects own RGB
// - Bit 11 is upper layer priority bit
// - Bit 10 selects RGB or YC video
// - Bit 9 moves foreground origin to 512
// - TV sync mode holds composite sync high
// - Priority codes set layer stacking order
//
`timescale 1ns/10ps
module dmc_display_mode_control
   import dmc_pkg::*;
#(
   parameter int REFRESH_GAP = DMC_REFRESH_GAP_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic hsync_n,
   input wire logic vsync_n,
   input wire logic display_area,
   output logic refresh_strobe,
   output dmc_disp_t disp_o
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0] hs_meta_q, hs_meta_d;
   logic [1:0] hs_sync_q, hs_sync_d;
   logic hs_prev_q, hs_prev_d;

   always_comb begin
      hs_meta_d = {vsync_n, hsync_n};
      hs_sync_d = hs_meta_q;
      hs_prev_d = hs_sync_q[0];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hs_meta_q <= 2'h3;
         hs_sync_q <= 2'h3;
         hs_prev_q <= 1'b1;
      end else begin
         hs_meta_q <= hs_meta_d;
         hs_sync_q <= hs_sync_d;
         hs_prev_q <= hs_prev_d;
      end
   end

   logic raster_start;
   assign raster_start = hs_prev_q && !hs_sync_q[0];

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [3:0] refresh_q, refresh_d;
   logic cde_off_q, cde_off_d;
   logic pri_hi_q, pri_hi_d;
   logic fmt_q, fmt_d;
   logic origin_q, origin_d;
   logic pri_lo_q, pri_lo_d;
   // Power-up value only; reset leaves these bits alone
   logic [1:0] csy_q = 2'h0;
   logic [1:0] csy_d;
   logic [1:0] sync_mode_q, sync_mode_d;
   logic ref_busy;

   function automatic logic [31:0] dmc_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
      for (int i = 0; i < 4; i++) begin
         dmc_merge[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
      end
   endfunction : dmc_merge

   function automatic logic [31:0] dmc_read(input logic [3:0] addr, input logic [3:0] rf,
                                            input logic [15:0] m2, input logic [1:0] sm,
                                            input logic [2:0] st);
      case (addr)
         DMC_ADDR_REFRESH: dmc_read = {28'h0, rf};
         DMC_ADDR_MODE_TWO: dmc_read = {16'h0, m2};
         DMC_ADDR_SYNC: dmc_read = {30'h0, sm};
         DMC_ADDR_STATUS: dmc_read = {29'h0, st};
         default: dmc_read = 32'h0;
      endcase
   endfunction : dmc_read

   logic [15:0] mode_two_word;
   always_comb begin
      mode_two_word = 16'h0;
      mode_two_word[DMC_CDE_OFF_BIT] = cde_off_q;
      mode_two_word[DMC_PRI_HI_BIT] = pri_hi_q;
      mode_two_word[DMC_FMT_BIT] = fmt_q;
      mode_two_word[DMC_ORIGIN_BIT] = origin_q;
      mode_two_word[DMC_CSY_HI_BIT] = csy_q[1];
      mode_two_word[DMC_CSY_LO_BIT] = csy_q[0];
      mode_two_word[DMC_PRI_LO_BIT] = pri_lo_q;
   end

   logic [2:0] status_word;
   assign status_word = {ref_busy, disp_o.cde_pin_o, disp_o.tv_sync_mode};

   // ----------------------------------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------------------------------
   logic aw_have_q, aw_have_d;
   logic w_have_q, w_have_d;
   logic [3:0] waddr_q, waddr_d;
   logic [31:0] wdata_q, wdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic commit;
   logic [31:0] wmerged;

   assign s_axi_awready = !aw_have_q && !bvalid_q;
   assign s_axi_wready = !w_have_q && !bvalid_q;
   assign commit = aw_have_q && w_have_q;
   assign wmerged = dmc_merge(dmc_read(waddr_q, refresh_q, mode_two_word, sync_mode_q, status_word),
                              wdata_q, wstrb_q);

   always_comb begin
      aw_have_d = aw_have_q;
      w_have_d = w_have_q;
      waddr_d = waddr_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_have_d = 1'b1;
         waddr_d = {s_axi_awaddr[3:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_have_d = 1'b1;
         wdata_d = s_axi_wdata;
         wstrb_d = s_axi_wstrb;
      end
      if (commit) begin
         aw_have_d = 1'b0;
         w_have_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = (waddr_q == DMC_ADDR_STATUS) ? DMC_RESP_SLVERR : DMC_RESP_OKAY;
      end
      if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         waddr_q <= 4'h0;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= DMC_RESP_OKAY;
      end else begin
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
         waddr_q <= waddr_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   // ----------------------------------------------------------------
   // Register updates
   // ----------------------------------------------------------------
   always_comb begin
      refresh_d = refresh_q;
      cde_off_d = cde_off_q;
      pri_hi_d = pri_hi_q;
      fmt_d = fmt_q;
      origin_d = origin_q;
      pri_lo_d = pri_lo_q;
      csy_d = csy_q;
      sync_mode_d = sync_mode_q;
      if (commit && waddr_q == DMC_ADDR_REFRESH) begin
         refresh_d = wmerged[3:0];
      end
      if (commit && waddr_q == DMC_ADDR_MODE_TWO) begin
         cde_off_d = wmerged[DMC_CDE_OFF_BIT];
         pri_hi_d = wmerged[DMC_PRI_HI_BIT];
         fmt_d = wmerged[DMC_FMT_BIT];
         origin_d = wmerged[DMC_ORIGIN_BIT];
         pri_lo_d = wmerged[DMC_PRI_LO_BIT];
         csy_d = {wmerged[DMC_CSY_HI_BIT], wmerged[DMC_CSY_LO_BIT]};
      end
      if (commit && waddr_q == DMC_ADDR_SYNC) begin
         sync_mode_d = wmerged[1:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         refresh_q <= DMC_REFRESH_RST;
         cde_off_q <= 1'b0;
         pri_hi_q <= 1'b0;
         fmt_q <= 1'b0;
         origin_q <= 1'b0;
         pri_lo_q <= 1'b0;
         sync_mode_q <= DMC_SYNC_RST;
      end else begin
         refresh_q <= refresh_d;
         cde_off_q <= cde_off_d;
         pri_hi_q <= pri_hi_d;
         fmt_q <= fmt_d;
         origin_q <= origin_d;
         pri_lo_q <= pri_lo_d;
         sync_mode_q <= sync_mode_d;
      end
   end

   always_ff @(posedge aclk) begin
      csy_q <= csy_d;
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------
   logic rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;

   assign s_axi_arready = !rvalid_q;

   always_comb begin
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_d = 1'b1;
         rdata_d = dmc_read({s_axi_araddr[3:2], 2'h0}, refresh_q, mode_two_word, sync_mode_q,
                            status_word);
         rresp_d = DMC_RESP_OKAY;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= DMC_RESP_OKAY;
      end else begin
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   // ----------------------------------------------------------------
   // Refresh timing
   // ----------------------------------------------------------------
   dmc_refresh_gen #(
      .CNT_W(4),
      .GAP_CYC(REFRESH_GAP)
   ) u_refresh (
      .aclk(aclk),
      .aresetn(aresetn),
      .raster_start(raster_start),
      .display_area(display_area),
      .refresh_count(refresh_q),
      .refresh_strobe(refresh_strobe),
      .busy(ref_busy)
   );

   // ----------------------------------------------------------------
   // Display control outputs
   // ----------------------------------------------------------------
   dmc_disp_t disp_q, disp_d;
   logic tv_mode;
   assign tv_mode = (sync_mode_q == DMC_SYNC_TV);

   always_comb begin
      disp_d = disp_q;
      // pin driver gated by bit 12
      disp_d.cde_pin_oe = !cde_off_q;
      // pin marks display area as active in every sync mode
      disp_d.cde_pin_o = display_area;
      disp_d.own_rgb_sel = tv_mode && display_area;
      disp_d.yc_convert = fmt_q;
      disp_d.fg1_origin_x = origin_q ? DMC_ORIGIN_HALF : 10'h000;
      disp_d.layer_order = dmc_layer_order({pri_hi_q, pri_lo_q});
      // composite sync held high in TV mode
      disp_d.csync_n = tv_mode ? 1'b1 : !(hs_sync_q[0] ^ hs_sync_q[1]);
      disp_d.tv_sync_mode = tv_mode;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         disp_q <= '{cde_pin_o: 1'b0, cde_pin_oe: 1'b0, own_rgb_sel: 1'b0, yc_convert: 1'b0,
                     fg1_origin_x: 10'h000, layer_order: 15'h0000, csync_n: 1'b1,
                     tv_sync_mode: 1'b0};
      end else begin
         disp_q <= disp_d;
      end
   end

   assign disp_o = disp_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   // reset value of refresh count
   AST_REFRESH_RST: assert property (@(posedge aclk) !aresetn |=> refresh_q == DMC_REFRESH_RST)
      else $error("refresh count not eight after reset");
   // reset clears mode bits, keeps sync
   AST_MODE_TWO_RST: assert property (@(posedge aclk)
      !aresetn |=> (mode_two_word & 16'hFF3F) == 16'h0000 && csy_q == $past(csy_q))
      else $error("display_mode_two reset behaviour wrong");
   AST_REFRESH_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
      refresh_q == 4'h0 && !ref_busy |=> !refresh_strobe)
      else $error("refresh strobe with zero count");
   AST_REFRESH_START: assert property (@(posedge aclk) disable iff (!aresetn)
      raster_start && display_area && !ref_busy && refresh_q != 4'h0 |-> ##2 refresh_strobe)
      else $error("refresh burst did not start");
   AST_CDE_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
      cde_off_q |=> !disp_o.cde_pin_oe)
      else $error("composite enable pin driven while disabled");
   // TV mode pin selects own RGB
   AST_TV_SELECT: assert property (@(posedge aclk) disable iff (!aresetn)
      tv_mode && display_area |=> disp_o.own_rgb_sel && disp_o.cde_pin_o)
      else $error("own RGB select missing in TV sync mode");
   AST_TV_CSYNC: assert property (@(posedge aclk) disable iff (!aresetn)
      tv_mode [*2] |=> disp_o.csync_n)
      else $error("composite sync low in TV sync mode");
   AST_LAYER_DEFAULT: assert property (@(posedge aclk) disable iff (!aresetn)
      !pri_hi_q && !pri_lo_q |=> disp_o.layer_order == {DMC_L_CUR1, DMC_L_CUR2, DMC_L_FG,
                                                          DMC_L_VID, DMC_L_BG})
      else $error("layer order wrong for priority 00");
   AST_LAYER_HI: assert property (@(posedge aclk) disable iff (!aresetn)
      pri_hi_q |=> disp_o.layer_order[5:3] == DMC_L_CUR2)
      else $error("upper priority bit has no effect");
   AST_YC: assert property (@(posedge aclk) disable iff (!aresetn)
      fmt_q |=> disp_o.yc_convert)
      else $error("YC conversion not selected");
   AST_ORIGIN: assert property (@(posedge aclk) disable iff (!aresetn)
      origin_q |=> disp_o.fg1_origin_x == DMC_ORIGIN_HALF)
      else $error("foreground origin not at 512");
   AST_READBACK: assert property (@(posedge aclk) disable iff (!aresetn)
      commit && waddr_q == DMC_ADDR_MODE_TWO && wstrb_q[1:0] == 2'h3 |=>
      mode_two_word == (wdata_q[15:0] & 16'h1EE0))
      else $error("display_mode_two does not read back");

   COV_WRITE_MODE: cover property (@(posedge aclk) disable iff (!aresetn)
      commit && waddr_q == DMC_ADDR_MODE_TWO);
   COV_BURST: cover property (@(posedge aclk) disable iff (!aresetn)
      refresh_strobe ##[1:8] refresh_strobe);
   COV_TV_MODE: cover property (@(posedge aclk) disable iff (!aresetn) $rose(tv_mode));

endmodule : dmc_display_mode_control

/* verification/display_mode_control_test.sv */
`timescale 1ns/10ps
module display_mode_control_test
   import dmc_pkg::*;
();
   // ----------------
   // Design and clock
   // ----------------
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic hsync_n, vsync_n, display_area;
   logic awready, wready, bvalid, arready, rvalid, refresh_strobe;
   logic [3:0] awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata, d;
   logic [1:0] bresp, rresp, r;
   dmc_disp_t disp;
   int n_mismatch, num_checks;

   always #5 aclk = ~aclk;

   dmc_display_mode_control #(.REFRESH_GAP(2)) dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .hsync_n(hsync_n), .vsync_n(vsync_n), .display_area(display_area),
      .refresh_strobe(refresh_strobe), .disp_o(disp));

   // ----------------
   // Shared tasks
   // ----------------
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : complete_run

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   task automatic lost(input string what);
      n_mismatch++;
      $display("unexpected at %0t: no answer to %s", $time, what);
      complete_run();
   endtask : lost

   task automatic do_reset();
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
   endtask : do_reset

   task automatic axi_write(input logic [3:0] a, input logic [31:0] v, output logic [1:0] resp);
      logic pa;
      logic pw;
      pa = 1'b1;
      pw = 1'b1;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (int i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (!pa && !pw && bvalid) begin
            resp = bresp;
            return;
         end
         if (pa && awready) begin
            pa = 1'b0;
            awvalid <= 1'b0;
         end
         if (pw && wready) begin
            pw = 1'b0;
            wvalid <= 1'b0;
         end
      end
      lost("write");
   endtask : axi_write

   task automatic axi_read(input logic [3:0] a, output logic [31:0] v);
      araddr <= a;
      arvalid <= 1'b1;
      for (int i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (!arvalid && rvalid) begin
            v = rdata;
            return;
         end
         if (arready) begin
            arvalid <= 1'b0;
         end
      end
      lost("read");
   endtask : axi_read

   task automatic run_raster(input logic area, input logic [31:0] exp);
      logic [31:0] cnt;
      cnt = 0;
      display_area <= area;
      hsync_n <= 1'b0;
      for (int i = 0; i < 60; i++) begin
         @(posedge aclk);
         cnt = cnt + refresh_strobe;
      end
      hsync_n <= 1'b1;
      display_area <= 1'b1;
      // Let the synchronised line see high so the next raster has a falling edge
      repeat (4) @(posedge aclk);
      check(cnt, exp, "refresh strobes per raster");
   endtask : run_raster

   // ----------------
   // Scenarios
   // ----------------
   task automatic test_power_up();
      axi_read(DMC_ADDR_MODE_TWO, d);
      check(d & 32'hFFFFFF3F, 32'h0, "mode two after power up");
      axi_write(DMC_ADDR_SYNC, 32'h2, r);
      check(r, DMC_RESP_OKAY, "write response");
      axi_write(DMC_ADDR_STATUS, 32'h0, r);
      check(r, DMC_RESP_SLVERR, "status write response");
      $display("test_power_up done");
   endtask : test_power_up

   task automatic test_refresh();
      logic [3:0] cnts [3];
      cnts = '{4'h0, 4'h1, 4'hF};
      run_raster(1'b1, 32'h8);
      run_raster(1'b0, 32'h0);
      for (int i = 0; i < 3; i++) begin
         axi_write(DMC_ADDR_REFRESH, {28'h0, cnts[i]}, r);
         run_raster(1'b1, {28'h0, cnts[i]});
      end
      $display("test_refresh done");
   endtask : test_refresh

   task automatic test_mode_two();
      logic [15:0] val [3];
      logic [14:0] ord [3];
      // origin bit only with legal bit mode
      val = '{16'h0800, 16'h0000, 16'h1EE0};
      ord = '{{DMC_L_CUR1, DMC_L_FG, DMC_L_VID, DMC_L_CUR2, DMC_L_BG},
              {DMC_L_CUR1, DMC_L_CUR2, DMC_L_FG, DMC_L_VID, DMC_L_BG},
              {DMC_L_FG, DMC_L_VID, DMC_L_CUR1, DMC_L_CUR2, DMC_L_BG}};
      display_area <= 1'b0;
      // Master sync mode so the composite sync bits may be set
      axi_write(DMC_ADDR_SYNC, 32'h0, r);
      for (int i = 0; i < 3; i++) begin
         axi_write(DMC_ADDR_MODE_TWO, {16'h0, val[i]}, r);
         axi_read(DMC_ADDR_MODE_TWO, d);
         check(d, {16'h0, val[i]}, "mode two readback");
         check(disp.cde_pin_oe, !val[i][12], "pin enable");
         check(disp.layer_order, ord[i], "layer order");
         check(disp.yc_convert, val[i][10], "video format");
         check(disp.fg1_origin_x, val[i][9] ? 10'h200 : 10'h000, "origin");
      end
      check(disp.tv_sync_mode, 1'b0, "sync mode");
      display_area <= 1'b1;
      @(posedge aclk);
      $display("test_mode_two done");
   endtask : test_mode_two

   task automatic test_reset_keep();
      do_reset();
      axi_read(DMC_ADDR_MODE_TWO, d);
      check(d, 32'h000000C0, "mode two after reset");
      axi_read(DMC_ADDR_REFRESH, d);
      check(d, 32'h8, "refresh count after reset");
      check(disp.tv_sync_mode, 1'b1, "sync mode");
      check(disp.csync_n, 1'b1, "composite sync");
      check(disp.own_rgb_sel, 1'b1, "rgb select");
      check(disp.cde_pin_oe, 1'b1, "pin enable");
      $display("test_reset_keep done");
   endtask : test_reset_keep

   // ----------------
   // Main sequence
   // ----------------
   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      {awvalid, wvalid, arvalid} = 3'h0;
      {bready, rready} = 2'h3;
      {awaddr, araddr, wdata} = 40'h0;
      wstrb = 4'hF;
      {hsync_n, vsync_n, display_area} = 3'h7;
      n_mismatch = 0;
      num_checks = 0;
      do_reset();
      test_power_up();
      test_refresh();
      test_mode_two();
      test_reset_keep();
      complete_run();
   end
endmodule : display_mode_control_test
